//--- pkg/smps_pkg.sv
// package: constants for the synchronous memory port slave
package smps_pkg;
  // ====================================================================
  // geometry
  localparam int unsigned DATA_WIDTH  = 32;
  localparam int unsigned ADDR_WIDTH  = 12;
  localparam int unsigned DEPTH       = 4096;
  localparam int unsigned LANES       = 4;
  localparam int unsigned LANE_WIDTH  = 8;
  // ====================================================================
  // host controller settings the device is built for
  localparam int unsigned READ_LATENCY  = 2;
  localparam int unsigned WRITE_LATENCY = 0;
  localparam logic        READ_STROBE_SELECT = 1'b1;
  localparam logic [3:0]  MEMORY_TYPE_64 = 4'hE;
  localparam logic [3:0]  MEMORY_TYPE_32 = 4'h4;
  localparam logic [3:0]  MEMORY_TYPE_16 = 4'hB;
  // ====================================================================
  // timing
  localparam int unsigned HOST_CLOCK_MHZ = 180;
  localparam int unsigned REF_CLOCK_MHZ  = 40;
  localparam int unsigned SYNC_STAGES    = 2;
  // ====================================================================
  // reset values
  localparam logic [DATA_WIDTH-1:0] DATA_RESET = 32'h00000000;
  localparam logic [ADDR_WIDTH-1:0] ADDR_RESET = 12'h000;
  localparam logic [LANES-1:0]      LANE_OFF   = 4'hF;
endpackage : smps_pkg

//--- rtl/smps_sync_memory_port_slave.sv
// design: dual-ported memory presented to a host memory controller
`timescale 1ns/10ps
// Operation
// - host sees 4096 words of 32 bits
// - host port plus independent internal port
// - read data returned two clocks after command
// - write stored on the strobe clock
// - write strobe gated by chip select drives write enable
// - data pins enabled by output-enable strobe
// - select enables, lanes gate, address direct
// - registered variant captures all inputs except output enable first
// - registered variant accesses RAM next cycle
// - optional capture then opposite-phase RAM access
// - clocked from ref_clk, 40 MHz; host memory clock is sampled, not used as a clock
// - registered variant: zero write, two read
module smps_sync_memory_port_slave
  import smps_pkg::*;
(
  // clocking
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic                         clkEn,
  // host memory interface pins
  input  wire logic                         hostMemoryClock,
  input  wire logic                         chipSelect_n,
  input  wire logic                         syncWriteStrobe_n,
  input  wire logic                         syncOutputEnable_n,
  input  wire logic [smps_pkg::LANES-1:0]   byteLaneEnable_n,
  input  wire logic [smps_pkg::ADDR_WIDTH-1:0] hostAddress,
  input  wire logic [smps_pkg::DATA_WIDTH-1:0] hostDataIn,
  output logic      [smps_pkg::DATA_WIDTH-1:0] hostDataOut,
  output logic                              hostDataOe,
  // configuration
  input  wire logic                         registeredMode,
  input  wire logic                         oppositeEdge,
  // internal logic port
  input  wire logic                         intEnable,
  input  wire logic                         intWrite,
  input  wire logic [smps_pkg::LANES-1:0]   intLaneEnable,
  input  wire logic [smps_pkg::ADDR_WIDTH-1:0] intAddress,
  input  wire logic [smps_pkg::DATA_WIDTH-1:0] intWriteData,
  output logic      [smps_pkg::DATA_WIDTH-1:0] intReadData
);
  import smps_pkg::*;

  // ====================================================================
  // state
  typedef struct packed {
    logic [1:0]            clkSync;
    logic                  clkPrev;
    logic [1:0]            csSync;
    logic [1:0]            weSync;
    logic [1:0]            oeSync;
    logic [LANES-1:0]      beSync0;
    logic [LANES-1:0]      beSync1;
    logic [ADDR_WIDTH-1:0] adSync0;
    logic [ADDR_WIDTH-1:0] adSync1;
    logic [DATA_WIDTH-1:0] dSync0;
    logic [DATA_WIDTH-1:0] dSync1;
    logic                  capValid;
    logic                  capWrite;
    logic [LANES-1:0]      capLanes;
    logic [ADDR_WIDTH-1:0] capAddr;
    logic [DATA_WIDTH-1:0] capData;
    logic                  pendFall;
    logic [DATA_WIDTH-1:0] readStage;
    logic                  oeOut;
    logic [DATA_WIDTH-1:0] dataOut;
    logic [DATA_WIDTH-1:0] intData;
  } smps_state_t;

  smps_state_t st;
  smps_state_t next_st;
  logic [DATA_WIDTH-1:0] mem [DEPTH];

  logic                  rise;
  logic                  fall;
  logic                  accWrite;
  logic [LANES-1:0]      accLanes;
  logic [ADDR_WIDTH-1:0] accAddr;
  logic [DATA_WIDTH-1:0] accData;
  logic                  accFire;
  logic                  hostWr;
  logic                  hostRd;
  logic [DATA_WIDTH-1:0] hostWord;
  logic [DATA_WIDTH-1:0] intWord;
  logic                  hostLive;

  // ====================================================================
  // host clock edges, found on ref_clk after two flops
  assign rise = st.clkSync[1] & ~st.clkPrev;
  assign fall = ~st.clkSync[1] & st.clkPrev;

  // pin samples at a host clock rising edge
  logic                  pinSel;
  logic                  pinWe;
  assign pinSel = ~st.csSync[1];
  assign pinWe  = ~st.weSync[1];

  // direct variant uses pins at the edge; registered variant uses the capture
  always_comb
  begin
    if (registeredMode)
    begin
      // the capture flops feed the RAM directly: one host edge later, or half a cycle in opposite phase
      accWrite = st.capWrite;
      accLanes = st.capLanes;
      accAddr  = st.capAddr;
      accData  = st.capData;
      accFire  = st.capValid && (st.pendFall ? fall : rise);
    end
    else
    begin
      accWrite = pinWe;
      accLanes = ~st.beSync1;
      accAddr  = st.adSync1;
      accData  = st.dSync1;
      accFire  = pinSel && rise;
    end
  end

  assign hostWr = accFire && accWrite;
  assign hostRd = accFire && !accWrite;

  // ====================================================================
  // dual-ported storage; host port written last so it wins a collision
  always_ff @(posedge ref_clk)
  begin
    if (clkEn)
    begin
      if (intEnable && intWrite)
      begin
        for (int i = 0; i < LANES; i++)
        begin
          if (intLaneEnable[i] && !(hostWr && accLanes[i] && accAddr == intAddress))
            mem[intAddress][i*LANE_WIDTH +: LANE_WIDTH] <= intWriteData[i*LANE_WIDTH +: LANE_WIDTH];
        end
      end
      if (hostWr)
      begin
        for (int i = 0; i < LANES; i++)
        begin
          if (accLanes[i])
            mem[accAddr][i*LANE_WIDTH +: LANE_WIDTH] <= accData[i*LANE_WIDTH +: LANE_WIDTH];
        end
      end
    end
  end

  assign hostWord = mem[accAddr];
  assign intWord  = mem[intAddress];

  // ====================================================================
  // next state
  always_comb
  begin
    next_st          = st;
    next_st.clkSync  = {st.clkSync[0], hostMemoryClock};
    next_st.clkPrev  = st.clkSync[1];
    next_st.csSync   = {st.csSync[0], chipSelect_n};
    next_st.weSync   = {st.weSync[0], syncWriteStrobe_n};
    next_st.oeSync   = {st.oeSync[0], syncOutputEnable_n};
    next_st.beSync0  = byteLaneEnable_n;
    next_st.beSync1  = st.beSync0;
    next_st.adSync0  = hostAddress;
    next_st.adSync1  = st.adSync0;
    next_st.dSync0   = hostDataIn;
    next_st.dSync1   = st.dSync0;
    if (rise)
    begin
      next_st.capValid = pinSel;
      next_st.capWrite = pinWe;
      next_st.capLanes = ~st.beSync1;
      next_st.capAddr  = st.adSync1;
      next_st.capData  = st.dSync1;
      // phase fixed at capture so a mid-cycle change cannot access one word twice
      next_st.pendFall  = oppositeEdge;
      next_st.dataOut = st.readStage;
    end
    if (hostRd)
      next_st.readStage = hostWord;
    // full-cycle registered access leaves no time for the staging flop: word goes straight out
    if (hostRd && registeredMode && !st.pendFall)
      next_st.dataOut = hostWord;
    hostLive     = !st.csSync[1] && !st.oeSync[1];
    next_st.oeOut = hostLive;
    if (intEnable)
      next_st.intData = intWord;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
      st.csSync <= 2'h3;
      st.weSync <= 2'h3;
      st.oeSync <= 2'h3;
      st.beSync0 <= LANE_OFF;
      st.beSync1 <= LANE_OFF;
    end
    else if (clkEn)
      st <= next_st;
  end

  assign hostDataOut = st.dataOut;
  assign hostDataOe  = st.oeOut;
  assign intReadData = st.intData;

  // ====================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  release_off_a : assert property ((st.csSync[1] || st.oeSync[1]) |=> !hostDataOe)
    else $error("data pins driven while deselected");
  enable_follow_a : assert property (clkEn && !st.csSync[1] && !st.oeSync[1] |=> hostDataOe)
    else $error("data pins not enabled");
  read_stage_a : assert property (clkEn && hostRd |=> st.readStage == $past(hostWord))
    else $error("read word not staged");
  data_launch_a : assert property (clkEn && rise && !(registeredMode && !st.pendFall && hostRd)
                                   |=> hostDataOut == $past(st.readStage))
    else $error("read data not launched on host edge");
  reg_launch_a : assert property (clkEn && registeredMode && !st.pendFall && hostRd
                                  |=> hostDataOut == $past(hostWord))
    else $error("registered read data late");
  direct_write_a : assert property (clkEn && !registeredMode && hostWr && accLanes == 4'hF
                                   |=> mem[$past(accAddr)] == $past(accData))
    else $error("write not stored");
  capture_a : assert property (clkEn && rise |=> st.capAddr == $past(st.adSync1))
    else $error("address not captured");
  pend_next_a : assert property (clkEn && registeredMode && !st.pendFall && rise && st.capValid
                                 && st.capWrite && st.capLanes == 4'hF
                                 |=> mem[$past(st.capAddr)] == $past(st.capData))
    else $error("access not one cycle after capture");
  int_read_a : assert property (clkEn && intEnable |=> intReadData == $past(intWord))
    else $error("internal read wrong");

  write_c : cover property (hostWr);
  read_c  : cover property (hostRd ##[1:40] hostDataOe);
  reg_c   : cover property (registeredMode && oppositeEdge && hostWr);
  clash_c : cover property (hostWr && intEnable && intWrite && accAddr == intAddress);
endmodule : smps_sync_memory_port_slave

//--- tb/smps_host_model.sv
// host memory controller model driving the slave's pins
`timescale 1ns/10ps
// ====================================================================
// host controller
module smps_host_model
  import smps_pkg::*;
(
  // driven by the host
  output logic                                 hostMemoryClock,
  output logic                                 chipSelect_n,
  output logic                                 syncWriteStrobe_n,
  output logic                                 syncOutputEnable_n,
  output logic [smps_pkg::LANES-1:0]           byteLaneEnable_n,
  output logic [smps_pkg::ADDR_WIDTH-1:0]      hostAddress,
  output logic [smps_pkg::DATA_WIDTH-1:0]      hostDataIn,
  // driven by the slave
  input  wire logic [smps_pkg::DATA_WIDTH-1:0] hostDataOut,
  input  wire logic                            hostDataOe
);
  localparam logic [3:0] MEM_TYPE = MEMORY_TYPE_32;
  initial
  begin
    hostMemoryClock = 1'b0;
    {chipSelect_n, syncWriteStrobe_n, syncOutputEnable_n} = 3'h7;
    byteLaneEnable_n = LANE_OFF;
    hostAddress = ADDR_RESET;
    hostDataIn = DATA_RESET;
  end
  // far slower than the real clock so the sampling side sees every edge
  always #100 hostMemoryClock = ~hostMemoryClock;
  // pins change on the falling edge, half a period clear of the taking edge
  task automatic access(input logic sel, input logic wr, input logic [3:0] ln, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q, output logic oe);
    @(negedge hostMemoryClock);
    chipSelect_n = ~sel;
    syncWriteStrobe_n = ~wr;
    syncOutputEnable_n = wr;
    byteLaneEnable_n = ln;
    hostAddress = a;
    hostDataIn = d;
    @(posedge hostMemoryClock);
    repeat (wr ? 0 : 2) @(posedge hostMemoryClock);
    q = hostDataOut;
    oe = hostDataOe;
    @(negedge hostMemoryClock);
    {chipSelect_n, syncWriteStrobe_n, syncOutputEnable_n} = 3'h7;
    // a released bus must not keep showing the last word
    hostDataIn = ~d;
  endtask
endmodule // smps_host_model

//--- tb/testbench.sv
// self-checking bench for the synchronous memory port slave
`timescale 1ns/10ps
// ====================================================================
// bench top
module testbench;
  import smps_pkg::*;
  logic                  ref_clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  clkEn = 1'b1;
  logic                  registeredMode = 1'b0;
  logic                  oppositeEdge = 1'b0;
  logic                  intEnable = 1'b0;
  logic                  intWrite = 1'b0;
  logic [LANES-1:0]      intLaneEnable = 4'h0;
  logic [ADDR_WIDTH-1:0] intAddress = 12'h000;
  logic [DATA_WIDTH-1:0] intWriteData = 32'h00000000;
  logic [DATA_WIDTH-1:0] intReadData, hostDataOut, hostDataIn;
  logic [ADDR_WIDTH-1:0] hostAddress;
  logic [LANES-1:0]      byteLaneEnable_n;
  logic                  hostMemoryClock, chipSelect_n, syncWriteStrobe_n, syncOutputEnable_n, hostDataOe;
  int                    mismatches = 0;
  int                    n_compared = 0;
  always #12.5 ref_clk = ~ref_clk;
  smps_sync_memory_port_slave u_dut (.ref_clk, .rst, .clkEn, .hostMemoryClock, .chipSelect_n,
    .syncWriteStrobe_n, .syncOutputEnable_n, .byteLaneEnable_n, .hostAddress, .hostDataIn, .hostDataOut,
    .hostDataOe, .registeredMode, .oppositeEdge, .intEnable, .intWrite, .intLaneEnable, .intAddress,
    .intWriteData, .intReadData);
  smps_host_model u_host (.hostMemoryClock, .chipSelect_n, .syncWriteStrobe_n, .syncOutputEnable_n,
    .byteLaneEnable_n, .hostAddress, .hostDataIn, .hostDataOut, .hostDataOe);
  // ====================================================================
  // shared tasks
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hostWrite(input logic sel, input logic [3:0] ln, input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        oe;
    u_host.access(sel, 1'b1, ln, a, d, q, oe);
    compare("drive during write", 32'h0, {31'h0, oe});
  endtask
  task automatic hostRead(input logic sel, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        oe;
    u_host.access(sel, 1'b0, 4'h0, a, 32'h0, q, oe);
    compare("drive during read", {31'h0, sel}, {31'h0, oe});
    if (sel)
      compare("host read data", exp, q);
  endtask
  task automatic intOp(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    #2;
    {intEnable, intWrite, intLaneEnable, intAddress, intWriteData} = {1'b1, wr, 4'hF, a, d};
    @(posedge ref_clk);
    #2;
    {intEnable, intWrite} = 2'h0;
  endtask
  // ====================================================================
  // scenarios
  task automatic testDirect();
    hostWrite(1'b1, 4'h0, 12'hFFF, 32'hA5A55A5A);
    hostWrite(1'b1, 4'h0, 12'h000, 32'h12345678);
    hostRead(1'b1, 12'hFFF, 32'hA5A55A5A);
    hostWrite(1'b1, 4'hA, 12'hFFF, 32'hFFFFFFFF);
    hostRead(1'b1, 12'hFFF, 32'hA5FF5AFF);
    $display("test direct done");
  endtask
  task automatic testDeselect();
    hostWrite(1'b0, 4'h0, 12'h000, 32'hDEADDEAD);
    hostRead(1'b0, 12'h000, 32'h0);
    hostRead(1'b1, 12'h000, 32'h12345678);
    $display("test deselect done");
  endtask
  task automatic testInternal();
    // seed the word so the internal port never reads back an unwritten location
    hostWrite(1'b1, 4'h0, 12'h123, 32'h00000000);
    intOp(1'b1, 12'h123, 32'hCAFEF00D);
    hostRead(1'b1, 12'h123, 32'hCAFEF00D);
    hostWrite(1'b1, 4'h0, 12'h456, 32'h0BADBEEF);
    repeat (20) @(posedge ref_clk);
    intOp(1'b0, 12'h456, 32'h0);
    compare("internal read", 32'h0BADBEEF, intReadData);
    $display("test internal done");
  endtask
  task automatic testRegistered();
    for (int e = 0; e < 2; e++)
    begin
      @(posedge ref_clk);
      #2;
      {registeredMode, oppositeEdge} = {1'b1, e[0]};
      hostWrite(1'b1, 4'h0, 12'h010, 32'h0F0F0000 + e);
      hostWrite(1'b1, 4'h0, 12'h011, 32'h00F0F0F0 + e);
      repeat (20) @(posedge ref_clk);
      intOp(1'b0, 12'h010, 32'h0);
      compare("registered write", 32'h0F0F0000 + e, intReadData);
      hostRead(1'b1, 12'h010, 32'h0F0F0000 + e);
    end
    hostRead(1'b1, 12'h011, 32'h00F0F0F1);
    $display("test registered done");
  endtask
  task automatic testFreeze();
    hostWrite(1'b1, 4'h0, 12'h200, 32'h11111111);
    @(posedge ref_clk);
    #2;
    clkEn = 1'b0;
    intOp(1'b1, 12'h200, 32'h22222222);
    @(posedge ref_clk);
    #2;
    clkEn = 1'b1;
    intOp(1'b0, 12'h200, 32'h0);
    compare("frozen write", 32'h11111111, intReadData);
    $display("test freeze done");
  endtask
  // ====================================================================
  // run and verdict
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk);
    #2;
    rst = 1'b0;
    repeat (10) @(posedge ref_clk);
    testDirect();
    testDeselect();
    testInternal();
    testFreeze();
    testRegistered();
    give_verdict();
  end
  // a hang counts as a mismatch
  initial
  begin
    #200000;
    mismatches++;
    $display("BAD run length expected finish seen hang");
    give_verdict();
  end
endmodule // testbench
